// [design/startup_config_and_reset.v]
// Purpose: startup configuration registers and reset sequencer
// Assumes: all inputs except resetn synchronous to ref_clk; one bus cycle per clock
// Notes: resetn is the power-on reset; pin and internal resets are
// sequenced here and shown on core_reset
`timescale 1ns/1ns
`default_nettype none
`include "startup_config_consts.vh"

module startup_config_and_reset #(
    parameter POR_DELAY = `POR_DELAY_CYC,
    parameter WD_PRESCALE_LOG2 = `WD_PRESCALE_LOG2
) (
    // Clock and power-on reset
    input wire ref_clk,
    input wire resetn,
    // Register port
    input wire [5:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Mode straps, caught as reset ends
    input wire mode_b_pin,
    input wire mode_a_pin,
    // Reset pin, open drain
    input wire reset_pin_in,
    output reg reset_pin_out,
    output reg reset_pin_oe,
    // Reset sources and results
    input wire watchdog_service,
    input wire clock_fail,
    output reg core_reset,
    output reg [1:0] reset_vector_sel,
    // CPU address decode
    input wire [15:0] cpu_addr,
    output reg sel_regs,
    output reg sel_ram,
    output reg sel_rom,
    // Interrupt pin
    input wire irq_n_pin,
    output reg irq_request,
    // Stop mode
    input wire stop_enter,
    input wire stop_wake,
    output reg stop_active
);

    localparam ST_POR = 5'h01;
    localparam ST_DRIVE = 5'h02;
    localparam ST_SETTLE = 5'h04;
    localparam ST_WAIT_HIGH = 5'h08;
    localparam ST_RUN = 5'h10;

    reg [4:0] state;
    reg [11:0] seq_cnt;
    reg from_por;
    reg [1:0] pending_cause;
    reg special_mode_flag;
    reg expanded_mode;
    reg watchdog_disable;
    reg rom_enable;
    reg [7:0] memory_placement_map;
    reg [7:0] system_choice_bits;
    reg setup_written;
    reg placement_written;
    reg choice_written;
    reg [6:0] window_cnt;
    reg [WD_PRESCALE_LOG2-1:0] wd_prescale;
    reg [5:0] wd_ticks;
    reg wd_timeout;
    reg irq_n_prev;
    reg [11:0] stop_cnt;
    reg stop_waking;

    wire window_open = (window_cnt < 7'd`PROTECT_WINDOW_CYC);
    wire wr_setup = reg_wr && (reg_addr == `OFS_SETUP_LATCH);
    wire wr_place = reg_wr && (reg_addr == `OFS_PLACEMENT);
    wire wr_choice = reg_wr && (reg_addr == `OFS_SYSTEM_CHOICE);
    wire wr_mode = reg_wr && (reg_addr == `OFS_MODE_STATUS);
    wire setup_ok = special_mode_flag || !setup_written;
    wire place_ok = window_open && !placement_written;
    wire choice_ok = special_mode_flag ||
        (window_open && !choice_written);
    wire clk_mon_trip = clock_fail &&
        system_choice_bits[`OPT_CLK_MON];
    wire [3:0] ram_page =
        memory_placement_map[`PLACE_RAM_MSB:`PLACE_RAM_LSB];
    wire [3:0] reg_page =
        memory_placement_map[`PLACE_REG_MSB:`PLACE_REG_LSB];
    wire [3:0] rom_page = (expanded_mode && !special_mode_flag) ?
        `ROM_PAGE_EXPANDED : `ROM_PAGE_NORMAL;
    wire [1:0] rate = system_choice_bits[`OPT_RATE_MSB:`OPT_RATE_LSB];
    wire [5:0] rate_limit = (rate == 2'h0) ? 6'h00 :
        (rate == 2'h1) ? 6'h03 : (rate == 2'h2) ? 6'h0f : 6'h3f;

    // Reset sequencer
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state <= ST_POR;
            seq_cnt <= 12'h000;
            from_por <= 1'b1;
            pending_cause <= `CAUSE_POR_PIN;
            core_reset <= 1'b1;
            reset_vector_sel <= `CAUSE_POR_PIN;
            reset_pin_out <= 1'b0;
            reset_pin_oe <= 1'b0;
        end
        else
        begin
            seq_cnt <= seq_cnt + 12'h001;
            case (state)
                ST_POR:
                begin
                    if (seq_cnt == POR_DELAY - 1)
                    begin
                        seq_cnt <= 12'h000;
                        state <= ST_DRIVE;
                        reset_pin_oe <= 1'b1;
                    end
                end
                ST_DRIVE:
                begin
                    if (seq_cnt == `PIN_DRIVE_CYC - 1)
                    begin
                        seq_cnt <= 12'h000;
                        reset_pin_oe <= 1'b0;
                        state <= ST_SETTLE;
                    end
                end
                ST_SETTLE:
                begin
                    if (seq_cnt == `PIN_SAMPLE_CYC - 1)
                    begin
                        seq_cnt <= 12'h000;
                        reset_vector_sel <= (!reset_pin_in || from_por) ?
                            `CAUSE_POR_PIN : pending_cause;
                        state <= reset_pin_in ? ST_RUN : ST_WAIT_HIGH;
                        core_reset <= !reset_pin_in;
                    end
                end
                ST_WAIT_HIGH:
                begin
                    if (reset_pin_in)
                        state <= ST_RUN;
                    core_reset <= !reset_pin_in;
                end
                ST_RUN:
                begin
                    from_por <= 1'b0;
                    if (!reset_pin_in || wd_timeout || clk_mon_trip)
                    begin
                        core_reset <= 1'b1;
                        state <= ST_DRIVE;
                        reset_pin_oe <= 1'b1;
                        seq_cnt <= 12'h000;
                        pending_cause <= clk_mon_trip ?
                            `CAUSE_CLK_MON : `CAUSE_WATCHDOG;
                    end
                end
                default:
                    state <= ST_POR;
            endcase
        end
    end

    // Configuration registers, reloaded while the core is held in reset
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            special_mode_flag <= 1'b0;
            expanded_mode <= 1'b0;
            watchdog_disable <= 1'b0;
            rom_enable <= 1'b1;
            memory_placement_map <= `PLACE_RESET;
            system_choice_bits <= `OPT_RESET;
            setup_written <= 1'b0;
            placement_written <= 1'b0;
            choice_written <= 1'b0;
            window_cnt <= 7'h00;
        end
        else if (core_reset)
        begin
            // Straps are caught on every reset cycle, last one wins
            special_mode_flag <= !mode_b_pin;
            expanded_mode <= mode_a_pin;
            watchdog_disable <= !mode_b_pin;
            rom_enable <= 1'b1;
            memory_placement_map <= `PLACE_RESET;
            system_choice_bits <= `OPT_RESET;
            setup_written <= 1'b0;
            placement_written <= 1'b0;
            choice_written <= 1'b0;
            window_cnt <= 7'h00;
        end
        else
        begin
            if (window_open)
                window_cnt <= window_cnt + 7'h01;
            if (wr_setup && setup_ok)
            begin
                watchdog_disable <= reg_wdata[`SETUP_WD_DISABLE];
                rom_enable <= reg_wdata[`SETUP_ROM_ENABLE];
                setup_written <= 1'b1;
            end
            if (wr_place && place_ok)
            begin
                memory_placement_map <= reg_wdata;
                placement_written <= 1'b1;
            end
            if (wr_choice)
            begin
                system_choice_bits[`OPT_CLK_MON] <= reg_wdata[`OPT_CLK_MON];
                if (choice_ok)
                begin
                    system_choice_bits[`OPT_IRQ_EDGE:`OPT_STOP_DLY] <=
                        reg_wdata[`OPT_IRQ_EDGE:`OPT_STOP_DLY];
                    system_choice_bits[`OPT_RATE_MSB:`OPT_RATE_LSB] <=
                        reg_wdata[`OPT_RATE_MSB:`OPT_RATE_LSB];
                    choice_written <= 1'b1;
                end
            end
            // Software may leave special mode but never enter it
            if (wr_mode && !reg_wdata[`MODE_SPECIAL])
                special_mode_flag <= 1'b0;
        end
    end

    // Register read port, data one cycle after the strobe
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            reg_rdata <= 8'h00;
        else if (!reg_rd)
            reg_rdata <= 8'h00;
        else if (reg_addr == `OFS_SETUP_LATCH)
            reg_rdata <= {5'h00, watchdog_disable, rom_enable, 1'b0};
        else if (reg_addr == `OFS_PLACEMENT)
            reg_rdata <= memory_placement_map;
        else if (reg_addr == `OFS_SYSTEM_CHOICE)
            reg_rdata <= system_choice_bits & `OPT_MASK;
        else if (reg_addr == `OFS_MODE_STATUS)
            reg_rdata <= {4'h0, reset_vector_sel, expanded_mode,
                special_mode_flag};
        else
            reg_rdata <= 8'h00;
    end

    // Watchdog: prescaler then rate counter
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wd_prescale <= {WD_PRESCALE_LOG2{1'b0}};
            wd_ticks <= 6'h00;
            wd_timeout <= 1'b0;
        end
        else if (core_reset || watchdog_disable || watchdog_service ||
            stop_active)
        begin
            // The watchdog needs a running clock, so stop clears its prescaler and tick count
            wd_prescale <= {WD_PRESCALE_LOG2{1'b0}};
            wd_ticks <= 6'h00;
            wd_timeout <= 1'b0;
        end
        else
        begin
            wd_prescale <= wd_prescale + 1'b1;
            wd_timeout <= 1'b0;
            if (&wd_prescale)
            begin
                if (wd_ticks >= rate_limit)
                begin
                    wd_ticks <= 6'h00;
                    wd_timeout <= 1'b1;
                end
                else
                    wd_ticks <= wd_ticks + 6'h01;
            end
        end
    end

    // Address decode for the CPU
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sel_regs <= 1'b0;
            sel_ram <= 1'b0;
            sel_rom <= 1'b0;
        end
        else
        begin
            sel_regs <= 1'b0;
            sel_ram <= 1'b0;
            sel_rom <= 1'b0;
            if (cpu_addr[15:12] == reg_page && cpu_addr[11:6] == 6'h00)
                sel_regs <= 1'b1;
            else if (cpu_addr[15:12] == ram_page &&
                cpu_addr[11:8] == 4'h0 && cpu_addr[7:6] != 2'h0)
                sel_ram <= 1'b1;
            else if (rom_enable && cpu_addr[15:12] == rom_page)
                sel_rom <= 1'b1;
        end
    end

    // Interrupt pin recognition
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_n_prev <= 1'b1;
            irq_request <= 1'b0;
        end
        else
        begin
            irq_n_prev <= irq_n_pin;
            irq_request <= !irq_n_pin &&
                (irq_n_prev || !system_choice_bits[`OPT_IRQ_EDGE]);
        end
    end

    // Stop mode and its exit delay
    always @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stop_active <= 1'b0;
            stop_waking <= 1'b0;
            stop_cnt <= 12'h000;
        end
        else if (core_reset)
        begin
            stop_active <= 1'b0;
            stop_waking <= 1'b0;
            stop_cnt <= 12'h000;
        end
        else if (!stop_active)
            stop_active <= stop_enter;
        else if (!stop_waking)
        begin
            stop_waking <= stop_wake;
            stop_cnt <= 12'h000;
        end
        else
        begin
            if ((system_choice_bits[`OPT_STOP_DLY] &&
                stop_cnt == `STOP_LONG_CYC - 1) ||
                (!system_choice_bits[`OPT_STOP_DLY] &&
                stop_cnt == `STOP_SHORT_CYC - 1))
            begin
                stop_active <= 1'b0;
                stop_waking <= 1'b0;
            end
            else
                stop_cnt <= stop_cnt + 12'h001;
        end
    end
endmodule
`default_nettype wire

// [include/startup_config_consts.vh]
// Purpose: constants for the startup configuration and reset block
// Assumes: 8-bit register port, 16-bit CPU address space
// Notes: all times are counted in bus clock cycles
`ifndef STARTUP_CONFIG_CONSTS_VH
`define STARTUP_CONFIG_CONSTS_VH

// Register offsets inside the 64-byte control block
`define OFS_SETUP_LATCH 6'h3f
`define OFS_PLACEMENT 6'h3d
`define OFS_SYSTEM_CHOICE 6'h39
`define OFS_MODE_STATUS 6'h3c

// Setup latch fields
`define SETUP_WD_DISABLE 2
`define SETUP_ROM_ENABLE 1
`define SETUP_MASK 8'h06

// Placement map fields and reset value
`define PLACE_RAM_MSB 7
`define PLACE_RAM_LSB 4
`define PLACE_REG_MSB 3
`define PLACE_REG_LSB 0
`define PLACE_RESET 8'h01

// System choice fields and reset value
`define OPT_IRQ_EDGE 5
`define OPT_STOP_DLY 4
`define OPT_CLK_MON 3
`define OPT_RATE_MSB 1
`define OPT_RATE_LSB 0
`define OPT_MASK 8'h3b
`define OPT_PROTECTED 8'h33
`define OPT_RESET 8'h10

// Mode and reset status fields
`define MODE_SPECIAL 0
`define MODE_EXPANDED 1

// Reset cause codes, one per vector
`define CAUSE_POR_PIN 2'h0
`define CAUSE_CLK_MON 2'h1
`define CAUSE_WATCHDOG 2'h2

// Timing, in bus clock cycles
`define POR_DELAY_CYC 4064
`define PROTECT_WINDOW_CYC 64
`define PIN_DRIVE_CYC 4
`define PIN_SAMPLE_CYC 2
`define STOP_LONG_CYC 4000
`define STOP_SHORT_CYC 4
`define WD_PRESCALE_LOG2 15

// Memory pages
`define ROM_PAGE_EXPANDED 4'h7
`define ROM_PAGE_NORMAL 4'hf

`endif

// [testbench/reset_circuit_model.sv]
// Purpose: external reset circuit on the open-drain reset pin
// Assumes: pull-up on the pin, bench asks for a hold by level
// Notes: hold length is chosen by the bench, short or long
`timescale 1ns/1ns
`default_nettype none

module reset_circuit_model (
    // Request from the bench
    input wire logic ext_hold,
    // Open-drain reset pin
    input wire logic reset_pin_oe,
    input wire logic reset_pin_out,
    output logic reset_pin_level
);
    // Pull-up: a released pin reads high, never a stale level
    assign reset_pin_level = !ext_hold &&
        (reset_pin_oe ? reset_pin_out : 1'b1);
endmodule

`default_nettype wire

// [testbench/startup_config_and_reset_asserts.sv]
// Purpose: port checker for the startup configuration block
// Assumes: one clock domain, resetn asynchronous active low
// Notes: attached by bind at the foot of this file
`timescale 1ns/1ns
`default_nettype none

module startup_config_and_reset_asserts (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // Register port
    input wire logic [5:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Reset pin and core
    input wire logic reset_pin_in,
    input wire logic reset_pin_oe,
    input wire logic core_reset,
    // Decode, interrupt, stop
    input wire logic [15:0] cpu_addr,
    input wire logic sel_regs,
    input wire logic sel_ram,
    input wire logic sel_rom,
    input wire logic irq_n_pin,
    input wire logic irq_request,
    input wire logic stop_wake,
    input wire logic stop_active
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic [3:0] wake_cnt;

    // Saturates so a stale wake never looks recent
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            wake_cnt <= 4'hf;
        else if (stop_wake)
            wake_cnt <= 4'h0;
        else if (wake_cnt != 4'hf)
            wake_cnt <= wake_cnt + 4'h1;
    end

    latch_zero_a:
    assert property ($past(reg_rd) && $past(reg_addr) == 6'h3f
        |-> reg_rdata[7:3] == 5'h00 && !reg_rdata[0])
    else $error("setup latch spare bits not zero");
    choice_zero_a:
    assert property ($past(reg_rd) && $past(reg_addr) == 6'h39
        |-> reg_rdata[7:6] == 2'h0 && !reg_rdata[2])
    else $error("choice spare bits not zero");
    pin_pulse_a:
    assert property ($rose(reset_pin_oe)
        |-> reset_pin_oe [*4] ##1 !reset_pin_oe [*2])
    else $error("reset pin pulse length wrong");
    core_hold_a:
    assert property (reset_pin_oe |-> core_reset)
    else $error("core running while pin driven");
    pin_wait_a:
    assert property (core_reset && !reset_pin_in && !reset_pin_oe
        |=> core_reset)
    else $error("left reset with pin low");
    por_hold_a:
    assert property ($rose(resetn) |-> core_reset [*8])
    else $error("power-on hold too short");
    irq_cause_a:
    assert property (irq_request |-> !$past(irq_n_pin))
    else $error("request without low pin");
    irq_fall_a:
    assert property ($fell(irq_n_pin) && !core_reset |=> irq_request)
    else $error("falling pin not recognised");
    stop_wake_a:
    assert property ($fell(stop_active) && !core_reset
        |-> wake_cnt >= 4'h3)
    else $error("stop exit too early");
    dec_prio_a:
    assert property ($onehot0({sel_regs, sel_ram, sel_rom}))
    else $error("several selects at once");
    rom_page_a:
    assert property (sel_rom |-> $past(cpu_addr[15:12]) == 4'h7
        || $past(cpu_addr[15:12]) == 4'hf)
    else $error("rom decoded off its page");
    regs_page_a:
    assert property (sel_regs |-> $past(cpu_addr[11:6]) == 6'h00)
    else $error("register block beyond 64 bytes");
endmodule

bind startup_config_and_reset startup_config_and_reset_asserts
    startup_config_and_reset_asserts_inst (.ref_clk, .resetn, .reg_addr,
    .reg_rd, .reg_rdata, .reset_pin_in, .reset_pin_oe, .core_reset,
    .cpu_addr, .sel_regs, .sel_ram, .sel_rom, .irq_n_pin, .irq_request,
    .stop_wake, .stop_active);

`default_nettype wire

// [testbench/startup_config_and_reset_tb.sv]
// Purpose: self-checking bench for the startup configuration block
// Assumes: short power-on and watchdog counts set by parameter
// Notes: straps and the external reset circuit set per scenario
`timescale 1ns/1ns
`default_nettype none

module startup_config_and_reset_tb;
    localparam POR = 16;
    localparam WDL = 4;
    logic ref_clk, resetn, reg_wr, reg_rd, mode_b_pin, mode_a_pin;
    logic watchdog_service, clock_fail, irq_n_pin, stop_enter, stop_wake;
    logic ext_hold;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [15:0] cpu_addr;
    wire [7:0] reg_rdata;
    wire [1:0] reset_vector_sel;
    wire reset_pin_in, reset_pin_out, reset_pin_oe, core_reset;
    wire sel_regs, sel_ram, sel_rom, irq_request, stop_active;
    int error_cnt;
    int check_count;

    startup_config_and_reset #(.POR_DELAY(POR), .WD_PRESCALE_LOG2(WDL))
        startup_config_and_reset_inst (.ref_clk, .resetn, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mode_b_pin, .mode_a_pin,
        .reset_pin_in, .reset_pin_out, .reset_pin_oe, .watchdog_service,
        .clock_fail, .core_reset, .reset_vector_sel, .cpu_addr, .sel_regs,
        .sel_ram, .sel_rom, .irq_n_pin, .irq_request, .stop_enter,
        .stop_wake, .stop_active);
    reset_circuit_model reset_circuit_model_inst (.ext_hold, .reset_pin_oe,
        .reset_pin_out, .reset_pin_level(reset_pin_in));

    task automatic complete_run;
        if (error_cnt == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int n, input int lo, input int hi);
        check_count++;
        if (n < lo || n > hi)
        begin
            error_cnt++;
            $display("ERROR %0t count %0d not in %0d..%0d", $time, n, lo, hi);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wait_core(input logic v, output int n);
        n = 0;
        while (core_reset !== v)
        begin
            @(posedge ref_clk);
            n++;
            if (n > 9000)
            begin
                error_cnt++;
                $display("ERROR %0t core reset wait ran out", $time);
                complete_run();
            end
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        chk(reg_rdata, e);
    endtask

    task automatic dec(input logic [15:0] a, input logic [2:0] e);
        @(posedge ref_clk);
        cpu_addr <= a;
        cyc(2);
        chk({5'h00, sel_regs, sel_ram, sel_rom}, {5'h00, e});
    endtask

    task automatic power_on(input logic b, input logic a, input int hold);
        int n;
        resetn <= 1'b0;
        mode_b_pin <= b;
        mode_a_pin <= a;
        ext_hold <= (hold > 0);
        cyc(20);
        resetn <= 1'b1;
        if (hold > 0)
        begin
            cyc(POR + hold);
            chk({7'h00, core_reset}, 8'h01);
            ext_hold <= 1'b0;
        end
        wait_core(1'b0, n);
    endtask

    task automatic stop_time(input int lo, input int hi);
        int n;
        @(posedge ref_clk);
        stop_enter <= 1'b1;
        @(posedge ref_clk);
        stop_enter <= 1'b0;
        stop_wake <= 1'b1;
        @(posedge ref_clk);
        stop_wake <= 1'b0;
        n = 0;
        while (stop_active !== 1'b0 && n < 5000)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk_rng(n, lo, hi);
        if (n >= 5000)
            complete_run();
    endtask

    task automatic normal_regs;
        rd(6'h3f, 8'h02);
        rd(6'h3d, 8'h01);
        rd(6'h39, 8'h10);
        rd(6'h3b, 8'h00);
        wr(6'h3d, 8'hf1);
        wr(6'h3d, 8'h22);
        rd(6'h3d, 8'hf1);
        dec(16'h1000, 3'b100);
        dec(16'h103f, 3'b100);
        dec(16'hf040, 3'b010);
        dec(16'hf000, 3'b001);
        dec(16'h1040, 3'b000);
        wr(6'h39, 8'hff);
        wr(6'h39, 8'h00);
        rd(6'h39, 8'h33);
        wr(6'h3f, 8'hf9);
        wr(6'h3f, 8'hff);
        rd(6'h3f, 8'h00);
        dec(16'hf100, 3'b000);
        irq_n_pin <= 1'b0;
        cyc(2);
        chk({7'h00, irq_request}, 8'h01);
        cyc(1);
        chk({7'h00, irq_request}, 8'h00);
        irq_n_pin <= 1'b1;
    endtask

    task automatic dog_bite;
        int n;
        watchdog_service <= 1'b0;
        wait_core(1'b1, n);
        chk_rng(n, 1020, 1030);
        wait_core(1'b0, n);
        chk({6'h00, reset_vector_sel}, 8'h02);
        watchdog_service <= 1'b1;
        rd(6'h3f, 8'h02);
    endtask

    task automatic ext_pin;
        int n;
        mode_a_pin <= 1'b1;
        ext_hold <= 1'b1;
        wait_core(1'b1, n);
        cyc(12);
        ext_hold <= 1'b0;
        wait_core(1'b0, n);
        chk({6'h00, reset_vector_sel}, 8'h00);
        dec(16'h7000, 3'b001);
        dec(16'hf000, 3'b000);
        rd(6'h39, 8'h10);
        irq_n_pin <= 1'b0;
        cyc(3);
        chk({7'h00, irq_request}, 8'h01);
        irq_n_pin <= 1'b1;
    endtask

    task automatic special_regs;
        int n;
        rd(6'h3f, 8'h06);
        wr(6'h3f, 8'h00);
        wr(6'h3f, 8'h02);
        rd(6'h3f, 8'h02);
        wr(6'h39, 8'h3b);
        wr(6'h39, 8'h20);
        rd(6'h39, 8'h20);
        cyc(64);
        wr(6'h3d, 8'h33);
        rd(6'h3d, 8'h01);
        dec(16'hf000, 3'b001);
        irq_n_pin <= 1'b0;
        cyc(3);
        chk({7'h00, irq_request}, 8'h00);
        irq_n_pin <= 1'b1;
        stop_time(4, 6);
        wr(6'h39, 8'h08);
        clock_fail <= 1'b1;
        wait_core(1'b1, n);
        clock_fail <= 1'b0;
        wait_core(1'b0, n);
        chk({6'h00, reset_vector_sel}, 8'h01);
        rd(6'h39, 8'h10);
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial
    begin
        error_cnt = 0;
        check_count = 0;
        {resetn, reg_wr, reg_rd, clock_fail, stop_enter, stop_wake} = 6'h00;
        {mode_b_pin, mode_a_pin, ext_hold} = 3'b100;
        {watchdog_service, irq_n_pin} = 2'b11;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        cpu_addr = 16'h0000;
        power_on(1'b1, 1'b0, 0);
        normal_regs();
        stop_time(4000, 4002);
        dog_bite();
        ext_pin();
        power_on(1'b0, 1'b1, 30);
        special_regs();
        complete_run();
    end
endmodule

`default_nettype wire
